// *** gnc_command_unit.sv ***
`default_nettype none
module gnc_command_unit (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // Command characters from the host link
  input  wire logic                rxValid,
  input  wire logic [7:0]          rxByte,
  output logic                     rxReady,
  // Echo
  output logic                     replyValid,
  output gnc_pkg::gnc_reply_t      reply,
  // Option straps from pins
  input  wire logic                nvPresent,
  input  wire logic                expandedGain,
  // Non-volatile storage
  output logic                     nvRdReq,
  output logic [3:0]               nvAddr,
  input  wire logic                nvRdValid,
  input  wire gnc_pkg::gnc_rec_t   nvRdData,
  output logic                     nvWrValid,
  output gnc_pkg::gnc_rec_t        nvWrData,
  // Applied gains
  output logic [31:0]              gainOut [gnc_pkg::NUM_CH],
  output logic                     gainUpdate
);
  import gnc_pkg::*;

  typedef enum {P_CMD, P_CHAN, P_VAL, P_FRAC, P_END, P_SKIP} gnc_pstate_t;
  typedef enum {
    S_BOOT, S_FETCH, S_IDLE, S_SETUP, S_WAIT1, S_CHECK, S_WAIT2, S_COMMIT, S_REPLY
  } gnc_state_t;

  gnc_pstate_t pState;
  gnc_state_t  state;
  logic [1:0]  optMeta;
  logic [1:0]  optSync;
  logic        isNR;
  logic        chanSeenR;
  logic        valSeenR;
  logic        fracSeenR;
  logic [7:0]  chanR;
  logic [19:0] valR;
  logic [3:0]  fracR;
  logic        cmdValid;
  gnc_cmd_t    cmd;
  gnc_cmd_t    finCmd;
  gnc_cmd_t    cmdR;
  logic        take;
  logic        isDigit;
  logic [7:0]  chanNext;
  logic [19:0] valNext;
  logic [19:0] sensVal;
  logic [3:0]  chanIdx;
  logic [15:0] sensR [NUM_CH];
  logic [15:0] expR [NUM_CH];
  logic [3:0]  levelR;
  logic [31:0] pendGain [NUM_CH];
  logic [3:0]  idxR;
  logic [3:0]  firstIdxR;
  logic [3:0]  lastIdxR;
  logic        bootR;
  logic        failR;
  logic [1:0]  bootCnt;
  logic [31:0] q4R;
  logic        divStart;
  logic [31:0] divNum;
  logic [31:0] divDen;
  logic        divDone;
  logic [31:0] divQuot;
  logic [15:0] curSens;
  logic [15:0] curExp;
  logic [3:0]  curLvl;
  logic [31:0] denC;
  logic [31:0] numC;
  logic [31:0] stepC;
  logic [31:0] minC;
  logic        outRange;
  logic        commitNow;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // Straps are static, but they still cross from the pins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      optMeta <= '0;
      optSync <= '0;
    end else begin
      optMeta <= {expandedGain, nvPresent};
      optSync <= optMeta;
    end
  end

  // Parser
  always_comb begin
    take     = rxValid && rxReady;
    isDigit  = (rxByte >= ASC_ZERO) && (rxByte <= ASC_NINE);
    chanNext = chanR * {4'h0, DEC_TEN} + {4'h0, rxByte[3:0]};
    valNext  = valR * {16'h0, DEC_TEN} + {16'h0, rxByte[3:0]};
    sensVal  = valR * {16'h0, DEC_TEN} + {16'h0, fracR};
    chanIdx  = cmd.chan[3:0] - 4'h1;
    finCmd.chan  = chanR[4:0];
    finCmd.value = valR[15:0];
    finCmd.op    = OP_BAD;
    if (chanSeenR && chanR <= MAX_CHAN) begin
      if (pState == P_END) begin
        if (isNR) begin
          finCmd.op = OP_QRY_SENS;
        end else if (chanR != 8'h00) begin
          finCmd.op = OP_QRY_EXP;
        end
      end else if ((pState == P_VAL || pState == P_FRAC) && valSeenR) begin
        if (isNR && chanR == 8'h00) begin
          if (!fracSeenR && valR >= 20'(LVL_MIN) && valR <= 20'(LVL_MAX)) begin
            finCmd.op = OP_SET_LVL;
          end
        end else if (isNR) begin
          if (sensVal <= VAL_CAP && sensVal != 20'h0) begin
            finCmd.op    = OP_SET_SENS;
            finCmd.value = sensVal[15:0];
          end
        end else if (chanR != 8'h00 && !fracSeenR && valR != 20'h0) begin
          finCmd.op = OP_SET_EXP;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pState    <= P_CMD;
      isNR      <= 1'b0;
      chanSeenR <= 1'b0;
      valSeenR  <= 1'b0;
      fracSeenR <= 1'b0;
      chanR     <= '0;
      valR      <= '0;
      fracR     <= '0;
      cmdValid  <= 1'b0;
      cmd       <= '0;
    end else begin
      cmdValid <= 1'b0;
      if (take) begin
        if (rxByte == ASC_CR) begin
          pState   <= P_CMD;
          cmdValid <= (pState != P_CMD);
          cmd      <= (pState == P_SKIP) ?
                      gnc_cmd_t'{op: OP_BAD, chan: 5'h0, value: 16'h0} : finCmd;
        end else begin
          case (pState)
            P_CMD: begin
              isNR      <= (rxByte == ASC_N);
              chanSeenR <= 1'b0;
              valSeenR  <= 1'b0;
              fracSeenR <= 1'b0;
              chanR     <= '0;
              valR      <= '0;
              fracR     <= '0;
              pState    <= (rxByte == ASC_N || rxByte == ASC_E) ? P_CHAN : P_SKIP;
            end
            P_CHAN: begin
              if (isDigit && chanNext <= MAX_CHAN) begin
                chanR     <= chanNext;
                chanSeenR <= 1'b1;
              end else if (rxByte == ASC_EQ && chanSeenR) begin
                pState <= P_VAL;
              end else if (rxByte == ASC_Q && chanSeenR) begin
                pState <= P_END;
              end else begin
                pState <= P_SKIP;
              end
            end
            P_VAL: begin
              if (isDigit && valNext <= VAL_CAP) begin
                valR     <= valNext;
                valSeenR <= 1'b1;
              end else if (rxByte == ASC_DOT && isNR && chanR != 8'h00) begin
                pState <= P_FRAC;
              end else begin
                pState <= P_SKIP;
              end
            end
            P_FRAC: begin
              if (isDigit && !fracSeenR) begin
                fracR     <= rxByte[3:0];
                fracSeenR <= 1'b1;
              end else begin
                pState <= P_SKIP;
              end
            end
            P_END:   pState <= P_SKIP;
            P_SKIP:  pState <= P_SKIP;
            default: pState <= P_SKIP;
          endcase
        end
      end
    end
  end

  // Candidate settings for the channel in hand
  always_comb begin
    curSens = sensR[idxR];
    curExp  = expR[idxR];
    curLvl  = levelR;
    if (!bootR) begin
      case (cmdR.op)
        OP_SET_SENS: curSens = cmdR.value;
        OP_SET_EXP:  curExp  = cmdR.value;
        OP_SET_LVL:  curLvl  = cmdR.value[3:0];
        default:     curLvl  = levelR;
      endcase
    end
    denC      = {16'h0, curSens} * {16'h0, curExp};
    numC      = {28'h0, curLvl} * GAIN_SCALE + (denC >> 1);
    stepC     = optSync[OPT_EXP] ? EXP_STEP : STD_STEP;
    minC      = optSync[OPT_EXP] ? EXP_MIN : STD_MIN;
    outRange  = (q4R > GAIN_MAX) || (q4R < minC);
    commitNow = (state == S_COMMIT);
  end

  gnc_divider u_div (
    .clock (clock),
    .reset (reset),
    .start (divStart),
    .numer (divNum),
    .denom (divDen),
    .busy  (),
    .done  (divDone),
    .quot  (divQuot)
  );

  // Sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state     <= S_BOOT;
      idxR      <= '0;
      firstIdxR <= '0;
      lastIdxR  <= '0;
      bootR     <= 1'b0;
      failR     <= 1'b0;
      bootCnt   <= '0;
      cmdR      <= '0;
      q4R       <= '0;
      divStart  <= 1'b0;
      divNum    <= '0;
      divDen    <= '0;
    end else begin
      divStart <= 1'b0;
      case (state)
        S_BOOT: begin
          bootCnt <= bootCnt + 2'h1;
          if (bootCnt == SYNC_SETTLE) begin
            idxR      <= '0;
            firstIdxR <= '0;
            lastIdxR  <= LAST_CH;
            bootR     <= 1'b1;
            state     <= optSync[OPT_NVM] ? S_FETCH : S_SETUP;
          end
        end
        S_FETCH: begin
          if (nvRdValid && nvRdReq) begin
            idxR  <= (idxR == LAST_CH) ? 4'h0 : idxR + 4'h1;
            state <= (idxR == LAST_CH) ? S_SETUP : S_FETCH;
          end
        end
        S_IDLE: begin
          if (cmdValid) begin
            cmdR  <= cmd;
            failR <= 1'b0;
            bootR <= 1'b0;
            if (cmd.op == OP_SET_LVL) begin
              idxR      <= '0;
              firstIdxR <= '0;
              lastIdxR  <= LAST_CH;
              state     <= S_SETUP;
            end else if (cmd.op == OP_SET_SENS || cmd.op == OP_SET_EXP) begin
              idxR      <= chanIdx;
              firstIdxR <= chanIdx;
              lastIdxR  <= chanIdx;
              state     <= S_SETUP;
            end
          end
        end
        S_SETUP: begin
          divNum   <= numC;
          divDen   <= denC;
          divStart <= 1'b1;
          state    <= S_WAIT1;
        end
        S_WAIT1: begin
          if (divDone) begin
            q4R   <= divQuot;
            state <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (outRange) begin
            failR <= 1'b1;
            state <= S_REPLY;
          end else begin
            divNum   <= q4R + (stepC >> 1);
            divDen   <= stepC;
            divStart <= 1'b1;
            state    <= S_WAIT2;
          end
        end
        S_WAIT2: begin
          if (divDone) begin
            idxR  <= (idxR == lastIdxR) ? firstIdxR : idxR + 4'h1;
            state <= (idxR == lastIdxR) ? S_COMMIT : S_SETUP;
          end
        end
        S_COMMIT: begin
          idxR  <= (idxR == lastIdxR) ? idxR : idxR + 4'h1;
          state <= (idxR == lastIdxR) ? S_REPLY : S_COMMIT;
        end
        S_REPLY: begin
          bootR <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Gains: all affected channels pass before any is applied
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gainUpdate <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        gainOut[i]  <= DEF_GAIN;
        pendGain[i] <= DEF_GAIN;
      end
    end else begin
      gainUpdate <= 1'b0;
      if (state == S_WAIT2 && divDone) begin
        pendGain[idxR] <= 32'(divQuot * stepC);
      end
      if (commitNow) begin
        gainOut[idxR] <= pendGain[idxR];
        gainUpdate    <= 1'b1;
      end
    end
  end

  // Settings
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      levelR <= DEF_LVL;
      for (int i = 0; i < NUM_CH; i++) begin
        sensR[i] <= DEF_SENS;
        expR[i]  <= DEF_EXP;
      end
    end else if (state == S_FETCH && nvRdValid && nvRdReq) begin
      sensR[idxR] <= (nvRdData.sens == 16'h0) ? DEF_SENS : nvRdData.sens;
      expR[idxR]  <= (nvRdData.expIn == 16'h0) ? DEF_EXP : nvRdData.expIn;
      levelR      <= (nvRdData.level < LVL_MIN || nvRdData.level > LVL_MAX) ?
                     DEF_LVL : nvRdData.level;
    end else if (commitNow && !bootR) begin
      sensR[idxR] <= curSens;
      expR[idxR]  <= curExp;
      levelR      <= curLvl;
    end
  end

  // Storage port
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      nvRdReq   <= 1'b0;
      nvAddr    <= '0;
      nvWrValid <= 1'b0;
      nvWrData  <= '0;
    end else begin
      nvRdReq   <= (state == S_FETCH) && !(nvRdValid && nvRdReq);
      nvWrValid <= commitNow && !bootR;
      if (state == S_FETCH || (commitNow && !bootR)) begin
        nvAddr <= idxR;
      end
      if (commitNow && !bootR) begin
        nvWrData <= '{sens: curSens, expIn: curExp, level: curLvl};
      end
    end
  end

  // Echo and host back-pressure
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      replyValid <= 1'b0;
      reply      <= '0;
      rxReady    <= 1'b0;
    end else begin
      replyValid <= 1'b0;
      rxReady    <= (state == S_IDLE) && !cmdValid;
      if (state == S_IDLE && cmdValid) begin
        reply.chan  <= cmd.chan;
        reply.level <= levelR;
        reply.sens  <= (cmd.chan == 5'h0) ? 16'h0 : sensR[chanIdx];
        reply.expIn <= (cmd.chan == 5'h0) ? 16'h0 : expR[chanIdx];
        case (cmd.op)
          OP_QRY_SENS: begin
            reply.kind <= RPL_SENS;
            replyValid <= 1'b1;
          end
          OP_QRY_EXP: begin
            reply.kind <= RPL_EXPECT;
            replyValid <= 1'b1;
          end
          OP_BAD: begin
            reply.kind <= RPL_SYNTAX;
            replyValid <= 1'b1;
          end
          default: replyValid <= 1'b0;
        endcase
      end else if (state == S_REPLY && !bootR) begin
        reply.kind  <= failR ? RPL_RANGE : RPL_ACCEPT;
        reply.chan  <= cmdR.chan;
        reply.level <= levelR;
        reply.sens  <= sensR[idxR];
        reply.expIn <= expR[idxR];
        replyValid  <= 1'b1;
      end
    end
  end

  a_sens_chan: assert property (
    cmdValid && cmd.op == OP_SET_SENS |-> cmd.chan >= 5'h01 && cmd.chan <= 5'h10)
    else $error("sensitivity command with bad channel");
  a_exp_chan: assert property (
    cmdValid && cmd.op == OP_SET_EXP |-> cmd.chan >= 5'h01 && cmd.chan <= 5'h10)
    else $error("expected-input command with bad channel");
  a_level_bounds: assert property (
    levelR >= LVL_MIN && levelR <= LVL_MAX)
    else $error("rack output level outside one to ten");
  a_div_result: assert property (
    divDone |-> ({32'h0, divQuot} * {32'h0, divDen} <= {32'h0, divNum}) &&
                ({32'h0, divQuot} * {32'h0, divDen} + {32'h0, divDen} > {32'h0, divNum}))
    else $error("gain quotient wrong");
  a_gain_limits: assert property (
    gainUpdate |-> gainOut[$past(idxR)] <= GAIN_MAX && gainOut[$past(idxR)] >= $past(minC))
    else $error("applied gain outside range");
  a_gain_step: assert property (
    gainUpdate |-> (gainOut[$past(idxR)] % $past(stepC)) == 32'h0)
    else $error("applied gain not on resolution");
  a_range_echo: assert property (
    state == S_CHECK && outRange && !bootR |=> ##1 (replyValid && reply.kind == RPL_RANGE))
    else $error("out-of-range echo missing");
  a_accept_echo: assert property (
    state == S_CHECK && !outRange && !bootR && idxR == lastIdxR |->
      ##[36:80] (replyValid && reply.kind == RPL_ACCEPT))
    else $error("acceptance echo missing");
  a_query_sens: assert property (
    state == S_IDLE && cmdValid && cmd.op == OP_QRY_SENS |=>
      replyValid && reply.kind == RPL_SENS && reply.level == levelR)
    else $error("sensitivity query reply wrong");
  a_query_exp: assert property (
    state == S_IDLE && cmdValid && cmd.op == OP_QRY_EXP |=>
      replyValid && reply.kind == RPL_EXPECT && reply.expIn == expR[reply.chan[3:0] - 4'h1])
    else $error("expected-input query reply wrong");
  a_reject_keep: assert property (
    replyValid && reply.kind == RPL_RANGE |-> $stable(levelR) && !$past(gainUpdate) &&
      !$past(nvWrValid))
    else $error("rejected command changed state");
  a_nv_store: assert property (
    commitNow && !bootR |=> nvWrValid && nvWrData.sens == sensR[nvAddr])
    else $error("settings not written to storage");
  a_defaults: assert property (
    $past(state) == S_BOOT && state == S_SETUP |->
      levelR == DEF_LVL && sensR[0] == DEF_SENS && expR[0] == DEF_EXP)
    else $error("defaults not loaded");
endmodule
`default_nettype wire

// *** gnc_pkg.sv ***
`default_nettype none
package gnc_pkg;
  localparam int NUM_CH = 16;
  localparam logic [3:0] LAST_CH = 4'hf;
  localparam logic [7:0] MAX_CHAN = 8'h10;

  // Command characters
  localparam logic [7:0] ASC_N    = 8'h4e;
  localparam logic [7:0] ASC_E    = 8'h45;
  localparam logic [7:0] ASC_EQ   = 8'h3d;
  localparam logic [7:0] ASC_Q    = 8'h3f;
  localparam logic [7:0] ASC_DOT  = 8'h2e;
  localparam logic [7:0] ASC_CR   = 8'h0d;
  localparam logic [7:0] ASC_ZERO = 8'h30;
  localparam logic [7:0] ASC_NINE = 8'h39;
  localparam logic [19:0] VAL_CAP = 20'h0ffff;
  localparam logic [3:0] DEC_TEN  = 4'ha;

  // Power-up settings: sensitivity in tenths of mV per unit
  localparam logic [15:0] DEF_SENS = 16'h2710;
  localparam logic [15:0] DEF_EXP  = 16'h0001;
  localparam logic [3:0]  DEF_LVL  = 4'h1;
  localparam logic [3:0]  LVL_MIN  = 4'h1;
  localparam logic [3:0]  LVL_MAX  = 4'ha;

  // Gains are held in units of 1e-4
  localparam logic [31:0] GAIN_SCALE = 32'h05f5e100;
  localparam logic [31:0] GAIN_MAX   = 32'h001e8480;
  localparam logic [31:0] STD_MIN    = 32'h000003e8;
  localparam logic [31:0] EXP_MIN    = 32'h00000019;
  localparam logic [31:0] STD_STEP   = 32'h000003e8;
  localparam logic [31:0] EXP_STEP   = 32'h0000000a;
  localparam logic [31:0] DEF_GAIN   = 32'h00002710;

  localparam logic [5:0] DIV_STEPS   = 6'h20;
  localparam logic [1:0] SYNC_SETTLE = 2'h3;
  localparam int OPT_NVM = 0;
  localparam int OPT_EXP = 1;

  typedef enum logic [2:0] {
    OP_SET_SENS, OP_SET_LVL, OP_SET_EXP, OP_QRY_SENS, OP_QRY_EXP, OP_BAD
  } gnc_op_t;

  typedef struct packed {
    gnc_op_t     op;
    logic [4:0]  chan;
    logic [15:0] value;
  } gnc_cmd_t;

  typedef struct packed {
    logic [15:0] sens;
    logic [15:0] expIn;
    logic [3:0]  level;
  } gnc_rec_t;

  typedef enum logic [2:0] {
    RPL_ACCEPT, RPL_RANGE, RPL_SENS, RPL_EXPECT, RPL_SYNTAX
  } gnc_kind_t;

  typedef struct packed {
    gnc_kind_t   kind;
    logic [4:0]  chan;
    logic [15:0] sens;
    logic [3:0]  level;
    logic [15:0] expIn;
  } gnc_reply_t;
endpackage
`default_nettype wire

// *** gnc_divider.sv ***
`default_nettype none
module gnc_divider (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Request
  input  wire logic        start,
  input  wire logic [31:0] numer,
  input  wire logic [31:0] denom,
  // Result
  output logic             busy,
  output logic             done,
  output logic [31:0]      quot
);
  import gnc_pkg::*;

  logic [31:0] remR;
  logic [5:0]  cntR;
  logic [32:0] shifted;
  logic [33:0] trial;

  // One quotient bit per cycle keeps the datapath to a single subtractor
  always_comb begin
    shifted = {remR, quot[31]};
    trial   = {1'b0, shifted} - {2'b00, denom};
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      quot <= '0;
      remR <= '0;
      cntR <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        quot <= numer;
        remR <= '0;
        cntR <= DIV_STEPS;
      end else if (busy) begin
        if (!trial[33]) begin
          remR <= trial[31:0];
          quot <= {quot[30:0], 1'b1};
        end else begin
          remR <= shifted[31:0];
          quot <= {quot[30:0], 1'b0};
        end
        cntR <= cntR - 6'h01;
        if (cntR == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** gnc_dummy_placeholder_never.sv ***
`default_nettype none
`default_nettype wire

// *** gnc_host_model.sv ***
`default_nettype none
module gnc_host_model (
  // Clock
  input  wire logic       clock,
  // Host byte link
  input  wire logic       rxReady,
  output var  logic       rxValid,
  output var  logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rxValid = 1'b0;
    rxByte  = 8'h00;
  end

  // Each byte stands until the edge that takes it; the CR ends the command
  task automatic send(input string s);
    logic [7:0] c;
    for (int i = 0; i <= s.len(); i++) begin
      c = (i == s.len()) ? 8'h0d : 8'(s[i]);
      rxValid <= 1'b1;
      rxByte  <= c;
      @(posedge clock);
      while (rxReady !== 1'b1) @(posedge clock);
    end
    rxValid <= 1'b0;
    // A released line must not keep showing the last character
    rxByte  <= ~c;
  endtask
endmodule
`default_nettype wire

// *** test_gain_normalize_command_unit.sv ***
`default_nettype none
module test_gain_normalize_command_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import gnc_pkg::*;

  logic        clock;
  logic        reset;
  logic        rxValid;
  logic        rxReady;
  logic [7:0]  rxByte;
  logic        replyValid;
  gnc_reply_t  reply;
  logic        nvPresent;
  logic        expandedGain;
  logic        nvRdReq;
  logic [3:0]  nvAddr;
  logic        nvRdValid;
  gnc_rec_t    nvRdData;
  logic        nvWrValid;
  gnc_rec_t    nvWrData;
  gnc_rec_t    mem [16];
  logic [31:0] gainOut [NUM_CH];
  logic        gainUpdate;
  int          sens [16];
  int          expv [16];
  int          lvl;
  longint      gm [16];
  int          err_total;
  int          compares;
  logic [31:0] seed = 32'h72d0;

  gnc_host_model host (.clock(clock), .rxReady(rxReady), .rxValid(rxValid), .rxByte(rxByte));

  gnc_command_unit dut (
    .clock(clock), .reset(reset), .rxValid(rxValid), .rxByte(rxByte), .rxReady(rxReady),
    .replyValid(replyValid), .reply(reply), .nvPresent(nvPresent),
    .expandedGain(expandedGain), .nvRdReq(nvRdReq), .nvAddr(nvAddr), .nvRdValid(nvRdValid),
    .nvRdData(nvRdData), .nvWrValid(nvWrValid), .nvWrData(nvWrData), .gainOut(gainOut),
    .gainUpdate(gainUpdate)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Storage answers one cycle after a request; between answers the data lines churn
  always @(posedge clock) begin
    nvRdValid <= nvRdReq && !nvRdValid;
    nvRdData  <= (nvRdReq && !nvRdValid) ? mem[nvAddr] : ~nvRdData;
    if (nvWrValid === 1'b1) mem[nvAddr] <= nvWrData;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Gain in units of 1e-4, or -1 when the option cannot reach it
  function automatic longint gain(int s, int e, int l, bit ex);
    longint d;
    longint q;
    longint st;
    d = longint'(s) * e;
    q = (longint'(l) * 100000000 + d / 2) / d;
    if (q > 2000000 || q < (ex ? 25 : 1000)) return -1;
    st = ex ? 10 : 1000;
    return (q + st / 2) / st * st;
  endfunction

  task automatic summarize();
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask

  task automatic chkGains();
    for (int i = 0; i < 16; i++) begin
      compares++;
      if (gainOut[i] !== 32'(gm[i])) fail($sformatf("gain of channel %0d", i + 1));
    end
  endtask

  task automatic chkReply(input gnc_kind_t k, input int ch);
    compares++;
    if (reply.kind !== k) fail("reply kind");
    if (k == RPL_SYNTAX) return;
    compares++;
    if (reply.chan !== 5'(ch) || reply.level !== 4'(lvl)) fail("reply channel or level");
    if ((k == RPL_SENS || k == RPL_EXPECT) && reply.sens !== 16'(sens[ch - 1])) fail("sens");
    if (k == RPL_EXPECT && reply.expIn !== 16'(expv[ch - 1])) fail("expected input");
  endtask

  task automatic chkRec(input int i);
    compares++;
    if (mem[i] !== {16'(sens[i]), 16'(expv[i]), 4'(lvl)}) fail("stored record");
  endtask

  task automatic waitReply();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (replyValid !== 1'b1 && n < 20000);
    if (n >= 20000) fail("no reply");
  endtask

  task automatic doReset(input bit nv);
    bit ok;
    int n;
    reset     <= 1'b1;
    nvPresent <= nv;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    ok  = 1;
    // The level is replicated per record; the last record read is the one kept
    lvl = (nv && mem[15].level inside {[1:10]}) ? mem[15].level : 1;
    for (int i = 0; i < 16; i++) begin
      sens[i] = (nv && mem[i].sens != 0) ? mem[i].sens : 10000;
      expv[i] = (nv && mem[i].expIn != 0) ? mem[i].expIn : 1;
      gm[i] = gain(sens[i], expv[i], lvl, expandedGain);
      ok &= gm[i] >= 0;
    end
    if (!ok) foreach (gm[i]) gm[i] = 10000;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rxReady !== 1'b1 && n < 5000);
    if (n >= 5000) fail("boot never ends");
  endtask

  // Model applies the whole command or nothing
  task automatic runSet(input bit isN, input int ch, input int v);
    int s [16];
    int e [16];
    int l;
    longint g [16];
    bit ok;
    s  = sens;
    e  = expv;
    l  = lvl;
    g  = gm;
    ok = 1;
    if (!isN) e[ch - 1] = v;
    else if (ch == 0) l = v;
    else s[ch - 1] = v;
    for (int i = 0; i < 16; i++) begin
      if (ch == 0 || i == ch - 1) begin
        g[i] = gain(s[i], e[i], l, expandedGain);
        ok &= g[i] >= 0;
      end
    end
    if (isN && ch > 0) host.send($sformatf("N%0d=%0d.%0d", ch, v / 10, v % 10));
    else host.send($sformatf("%s%0d=%0d", isN ? "N" : "E", ch, v));
    waitReply();
    if (ok) begin
      sens = s;
      expv = e;
      lvl  = l;
      gm   = g;
    end
    chkReply(ok ? RPL_ACCEPT : RPL_RANGE, ch);
    chkGains();
  endtask

  task automatic runQry(input bit isN, input int ch);
    host.send($sformatf("%s%0d?", isN ? "N" : "E", ch));
    waitReply();
    chkReply(isN ? RPL_SENS : RPL_EXPECT, ch);
  endtask

  task automatic runBad(input string s);
    host.send(s);
    waitReply();
    chkReply(RPL_SYNTAX, 0);
  endtask

  initial begin
    #3600000;
    fail("watchdog expired");
    summarize();
  end

  initial begin
    logic [31:0] r;
    int          v;
    reset        = 1'b1;
    nvPresent    = 1'b0;
    expandedGain = 1'b0;
    nvRdValid    = 1'b0;
    nvRdData     = '0;
    err_total    = 0;
    compares     = 0;
    foreach (mem[i]) mem[i] = '0;
    doReset(0);
    chkGains();
    runQry(1, 6);
    runQry(0, 6);
    runSet(1, 6, 112);
    expandedGain <= 1'b1;
    repeat (4) @(posedge clock);
    runSet(1, 7, 112);
    runSet(1, 0, 5);
    runSet(1, 0, 2);
    runSet(0, 1, 60000);
    runQry(0, 1);
    runSet(0, 16, 3);
    runBad("E0?");
    runBad("N17=1.0");
    for (int k = 0; k < 8; k++) begin
      r = xs();
      expandedGain <= r[0];
      repeat (4) @(posedge clock);
      v = r[1] ? 1 + int'(r[31:16]) % 65535 : 1 + int'(r[15:8]) % 40;
      runSet(r[1], 1 + int'(r[5:2]), v);
    end
    // Known records, one with a broken sensitivity field that must fall back
    foreach (mem[i]) mem[i] = '{sens: 16'h2710, expIn: 16'h0001, level: 4'h2};
    mem[2] = '{sens: 16'h01f4, expIn: 16'h0002, level: 4'h2};
    mem[4].sens = 16'h0000;
    doReset(1);
    chkGains();
    runQry(0, 3);
    runQry(1, 5);
    runSet(0, 3, 3);
    chkRec(2);
    summarize();
  end
endmodule
`default_nettype wire
